//--- awm_host_model.sv
// host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module awm_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr_en,
  output var  logic [7:0] reg_wr_data,
  output var  logic       reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid,
  // device mode seen by the host
  input  wire logic       active_select
);
  logic [7:0] shadow = 8'h00;
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // one byte write; address and data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~d;
  endtask
  // one byte read, answer taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask
  // field changes go through standby first; mode and one-shot bits are free
  task automatic ctrl(input logic [7:0] d);
    if (active_select && d[7:2] != shadow[7:2]) begin
      wr(awm_pkg::ADDR_CONTROL_ONE, {shadow[7:1], 1'b0});
    end
    wr(awm_pkg::ADDR_CONTROL_ONE, d);
    shadow = d;
  endtask
endmodule
`default_nettype wire

//--- awm_pkg.sv
// constants for the alarm window and min/max register bank
package awm_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PRESS_WINDOW_HIGH   = 8'h19;
  localparam logic [7:0] ADDR_PRESS_WINDOW_LOW    = 8'h1a;
  localparam logic [7:0] ADDR_TEMP_WINDOW         = 8'h1b;
  localparam logic [7:0] ADDR_PRESS_LOWEST_HIGH   = 8'h1c;
  localparam logic [7:0] ADDR_PRESS_LOWEST_MID    = 8'h1d;
  localparam logic [7:0] ADDR_PRESS_LOWEST_LOW    = 8'h1e;
  localparam logic [7:0] ADDR_TEMP_LOWEST_HIGH    = 8'h1f;
  localparam logic [7:0] ADDR_TEMP_LOWEST_LOW     = 8'h20;
  localparam logic [7:0] ADDR_PRESS_HIGHEST_HIGH  = 8'h21;
  localparam logic [7:0] ADDR_PRESS_HIGHEST_MID   = 8'h22;
  localparam logic [7:0] ADDR_PRESS_HIGHEST_LOW   = 8'h23;
  localparam logic [7:0] ADDR_TEMP_HIGHEST_HIGH   = 8'h24;
  localparam logic [7:0] ADDR_TEMP_HIGHEST_LOW    = 8'h25;
  localparam logic [7:0] ADDR_CONTROL_ONE         = 8'h26;

  // control_one field positions
  localparam int CTRL_ALT_BIT   = 7;
  localparam int CTRL_RAW_BIT   = 6;
  localparam int CTRL_OS_MSB    = 5;
  localparam int CTRL_OS_LSB    = 3;
  localparam int CTRL_RST_BIT   = 2;
  localparam int CTRL_OST_BIT   = 1;
  localparam int CTRL_ACTIVE_SELECT_BIT  = 0;

  // widths and reset values
  localparam int PRESS_WIN_W    = 16;
  localparam int TEMP_WIN_W     = 8;
  localparam int PRESS_MEAS_W   = 20;
  localparam int TEMP_MEAS_W    = 12;
  localparam int PRESS_CAP_W    = 24;
  localparam int TEMP_CAP_W     = 16;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
  localparam logic [2:0]  OS_RESET      = 3'h0;
  localparam logic [3:0]  FRAC_PAD      = 4'h0;
  localparam logic [7:0]  LOW_BYTE_MASK = 8'hf0;

  // byte index inside a captured group, high byte first
  localparam logic [1:0] BYTE_HIGH = 2'h0;
  localparam logic [1:0] BYTE_MID  = 2'h1;
  localparam logic [1:0] BYTE_LOW  = 2'h2;

endpackage

//--- awm_regs.sv
// alarm window, min/max capture and first control register bank
//
// Operation
// - pressure window is unsigned 16 bits
// - temperature window is unsigned 8 bits
// - minimum pressure in three bytes, high first
// - maximum pressure laid out like minimum
// - altimeter extremes: signed, 16.4 meters
// - barometer extremes: unsigned, 18.2 pascals
// - minimum temperature in two bytes, high first
// - maximum temperature in two bytes, high first
// - temperature extremes signed 8.4, low nibble zero
// - extremes clear at reset or by writing zero
// - control_one bit layout, all reset zero
// - altimeter select picks altitude or pressure
// - active select: standby or periodic acquisition
`timescale 1ns/1ps
`default_nettype none
module awm_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port from the serial front end
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output var  logic [7:0]  reg_rd_data,
  output var  logic        reg_rd_valid,
  // completed measurement from the acquisition chain
  input  wire logic        meas_valid,
  input  wire logic [19:0] meas_press,
  input  wire logic [11:0] meas_temp,
  // control towards the acquisition chain
  output var  logic        altimeter_select,
  output var  logic        raw_mode,
  output var  logic [2:0]  oversample_field,
  output var  logic        active_select,
  output var  logic        meas_start,
  output var  logic        soft_reset,
  // alarm windows towards the alarm logic
  output var  logic [15:0] press_window,
  output var  logic [7:0]  temp_window
);

  // control state
  logic                             altimeter_select_ff;
  logic                             raw_mode_ff;
  logic [2:0]                       oversample_field_ff;
  logic                             one_shot_trigger_ff;
  logic                             active_select_ff;
  logic                             soft_reset_ff;
  logic                             meas_start_ff;
  // windows
  logic [awm_pkg::PRESS_WIN_W-1:0]  press_window_ff;
  logic [awm_pkg::TEMP_WIN_W-1:0]   temp_window_ff;
  // read path
  logic [7:0]                       rd_data_ff;
  logic                             rd_valid_ff;
  logic [23:0]                      snap_ff;
  logic [7:0]                       nxt_rd_data;
  logic                             snap_load;
  logic [23:0]                      nxt_snap;
  // decoded writes
  logic                             wr_ctrl;
  logic                             bank_rstn;
  logic                             one_shot_rise;

  // tracker links
  // the pressure tracker also serves altitude
  awm_track_if #(.W(awm_pkg::PRESS_CAP_W)) press_trk ();
  awm_track_if #(.W(awm_pkg::TEMP_CAP_W))  temp_trk ();

  // software reset restarts the whole bank one cycle after the write;
  // a registered pulse keeps the clear out of
  // the very write that asked for it
  assign bank_rstn = rstn && !soft_reset_ff;
  assign wr_ctrl   = reg_wr_en && (reg_addr == awm_pkg::ADDR_CONTROL_ONE);
  assign one_shot_rise = wr_ctrl && reg_wr_data[awm_pkg::CTRL_OST_BIT] && !one_shot_trigger_ff;

  // control_one fields; the host keeps them steady while active
  // writes while active are still taken; going
  // through standby is the host's duty
  always_ff @(posedge clk) begin
    if (!bank_rstn) begin
      altimeter_select_ff <= 1'b0;
      raw_mode_ff         <= 1'b0;
      oversample_field_ff <= awm_pkg::OS_RESET;
    end else if (wr_ctrl) begin
      altimeter_select_ff <= reg_wr_data[awm_pkg::CTRL_ALT_BIT];
      raw_mode_ff         <= reg_wr_data[awm_pkg::CTRL_RAW_BIT];
      oversample_field_ff <= reg_wr_data[awm_pkg::CTRL_OS_MSB:awm_pkg::CTRL_OS_LSB];
    end
  end

  // standby/active select may change at any time
  // so the host can start or stop directly
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      active_select_ff <= 1'b0;
    else if (wr_ctrl)
      active_select_ff <= reg_wr_data[awm_pkg::CTRL_ACTIVE_SELECT_BIT];
  end

  // one-shot: auto clears after a measurement in standby, stays set while active
  // a write in the completion cycle wins
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      one_shot_trigger_ff <= 1'b0;
    else if (wr_ctrl)
      one_shot_trigger_ff <= reg_wr_data[awm_pkg::CTRL_OST_BIT];
    else if (meas_valid && !active_select_ff)
      one_shot_trigger_ff <= 1'b0;
  end

  // measurement kick, one cycle, only on a fresh 0 to 1 write
  // setting the bit again without a clear fires nothing
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      meas_start_ff <= 1'b0;
    else
      meas_start_ff <= one_shot_rise;
  end

  // software reset pulse; the bit itself always reads back as zero
  always_ff @(posedge clk) begin
    if (!rstn)
      soft_reset_ff <= 1'b0;
    else
      soft_reset_ff <= wr_ctrl && reg_wr_data[awm_pkg::CTRL_RST_BIT] && !soft_reset_ff;
  end

  // pressure/altitude window, two bytes
  // halves land one write apart, so the alarm
  // side may see a mixed value briefly
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      press_window_ff <= '0;
    else if (reg_wr_en && reg_addr == awm_pkg::ADDR_PRESS_WINDOW_HIGH)
      press_window_ff[15:8] <= reg_wr_data;
    else if (reg_wr_en && reg_addr == awm_pkg::ADDR_PRESS_WINDOW_LOW)
      press_window_ff[7:0] <= reg_wr_data;
  end

  // temperature window, one byte
  // never touched by measurements
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      temp_window_ff <= '0;
    else if (reg_wr_en && reg_addr == awm_pkg::ADDR_TEMP_WINDOW)
      temp_window_ff <= reg_wr_data;
  end

  // feed the pressure tracker; raw data carries no scale so it is not tracked
  // one byte lane per strobe, lane 0 is the high byte
  always_comb begin
    press_trk.clear        = soft_reset_ff;
    press_trk.sample_valid = meas_valid && !raw_mode_ff;
    press_trk.sample       = {meas_press, awm_pkg::FRAC_PAD};
    press_trk.signed_mode  = altimeter_select_ff;
    press_trk.wr_lowest    = 1'b0;
    press_trk.wr_highest   = 1'b0;
    press_trk.wr_byte      = awm_pkg::BYTE_HIGH;
    press_trk.wr_data      = reg_wr_data;
    if (reg_wr_en) begin
      unique case (reg_addr)
        awm_pkg::ADDR_PRESS_LOWEST_HIGH: begin
          press_trk.wr_lowest = 1'b1;
        end
        awm_pkg::ADDR_PRESS_LOWEST_MID: begin
          press_trk.wr_lowest = 1'b1;
          press_trk.wr_byte   = awm_pkg::BYTE_MID;
        end
        awm_pkg::ADDR_PRESS_LOWEST_LOW: begin
          press_trk.wr_lowest = 1'b1;
          press_trk.wr_byte   = awm_pkg::BYTE_LOW;
        end
        awm_pkg::ADDR_PRESS_HIGHEST_HIGH: begin
          press_trk.wr_highest = 1'b1;
        end
        awm_pkg::ADDR_PRESS_HIGHEST_MID: begin
          press_trk.wr_highest = 1'b1;
          press_trk.wr_byte    = awm_pkg::BYTE_MID;
        end
        awm_pkg::ADDR_PRESS_HIGHEST_LOW: begin
          press_trk.wr_highest = 1'b1;
          press_trk.wr_byte    = awm_pkg::BYTE_LOW;
        end
        default: begin
          press_trk.wr_lowest = 1'b0;
        end
      endcase
    end
  end

  // feed the temperature tracker; temperature is always signed
  // its low byte is lane 1 of the group
  always_comb begin
    temp_trk.clear        = soft_reset_ff;
    temp_trk.sample_valid = meas_valid && !raw_mode_ff;
    temp_trk.sample       = {meas_temp, awm_pkg::FRAC_PAD};
    temp_trk.signed_mode  = 1'b1;
    temp_trk.wr_lowest    = 1'b0;
    temp_trk.wr_highest   = 1'b0;
    temp_trk.wr_byte      = awm_pkg::BYTE_HIGH;
    temp_trk.wr_data      = reg_wr_data;
    if (reg_wr_en) begin
      unique case (reg_addr)
        awm_pkg::ADDR_TEMP_LOWEST_HIGH: begin
          temp_trk.wr_lowest = 1'b1;
        end
        awm_pkg::ADDR_TEMP_LOWEST_LOW: begin
          temp_trk.wr_lowest = 1'b1;
          temp_trk.wr_byte   = awm_pkg::BYTE_MID;
        end
        awm_pkg::ADDR_TEMP_HIGHEST_HIGH: begin
          temp_trk.wr_highest = 1'b1;
        end
        awm_pkg::ADDR_TEMP_HIGHEST_LOW: begin
          temp_trk.wr_highest = 1'b1;
          temp_trk.wr_byte    = awm_pkg::BYTE_MID;
        end
        default: begin
          temp_trk.wr_lowest = 1'b0;
        end
      endcase
    end
  end

  // trackers
  // pin reset direct, software reset via clear
  awm_tracker #(.W(awm_pkg::PRESS_CAP_W)) u_press_track (
    .clk  (clk),
    .rstn (rstn),
    .trk  (press_trk)
  );

  awm_tracker #(.W(awm_pkg::TEMP_CAP_W)) u_temp_track (
    .clk  (clk),
    .rstn (rstn),
    .trk  (temp_trk)
  );

  // a read of a group's high byte freezes the group, so the following
  // byte reads cannot mix two captures; one snapshot serves all groups
  // because the host reads a group as one burst;
  // limitation: a low byte read without its high
  // byte returns the group frozen last
  always_comb begin
    snap_load = 1'b0;
    nxt_snap  = snap_ff;
    if (reg_rd_en) begin
      unique case (reg_addr)
        awm_pkg::ADDR_PRESS_LOWEST_HIGH: begin
          snap_load = 1'b1;
          nxt_snap  = press_trk.lowest;
        end
        awm_pkg::ADDR_PRESS_HIGHEST_HIGH: begin
          snap_load = 1'b1;
          nxt_snap  = press_trk.highest;
        end
        awm_pkg::ADDR_TEMP_LOWEST_HIGH: begin
          snap_load = 1'b1;
          nxt_snap  = {temp_trk.lowest, 8'h00};
        end
        awm_pkg::ADDR_TEMP_HIGHEST_HIGH: begin
          snap_load = 1'b1;
          nxt_snap  = {temp_trk.highest, 8'h00};
        end
        default: begin
          snap_load = 1'b0;
        end
      endcase
    end
  end

  // snapshot register
  // software reset empties it, no stale group survives
  always_ff @(posedge clk) begin
    if (!bank_rstn)
      snap_ff <= '0;
    else if (snap_load)
      snap_ff <= nxt_snap;
  end

  // read multiplexer; lower bytes come from the snapshot
  // windows and control read live
  always_comb begin
    unique case (reg_addr)
      awm_pkg::ADDR_PRESS_WINDOW_HIGH:  nxt_rd_data = press_window_ff[15:8];
      awm_pkg::ADDR_PRESS_WINDOW_LOW:   nxt_rd_data = press_window_ff[7:0];
      awm_pkg::ADDR_TEMP_WINDOW:        nxt_rd_data = temp_window_ff;
      awm_pkg::ADDR_PRESS_LOWEST_HIGH:  nxt_rd_data = press_trk.lowest[23:16];
      awm_pkg::ADDR_PRESS_LOWEST_MID:   nxt_rd_data = snap_ff[15:8];
      awm_pkg::ADDR_PRESS_LOWEST_LOW:   nxt_rd_data = snap_ff[7:0];
      awm_pkg::ADDR_TEMP_LOWEST_HIGH:   nxt_rd_data = temp_trk.lowest[15:8];
      awm_pkg::ADDR_TEMP_LOWEST_LOW:    nxt_rd_data = snap_ff[15:8];
      awm_pkg::ADDR_PRESS_HIGHEST_HIGH: nxt_rd_data = press_trk.highest[23:16];
      awm_pkg::ADDR_PRESS_HIGHEST_MID:  nxt_rd_data = snap_ff[15:8];
      awm_pkg::ADDR_PRESS_HIGHEST_LOW:  nxt_rd_data = snap_ff[7:0];
      awm_pkg::ADDR_TEMP_HIGHEST_HIGH:  nxt_rd_data = temp_trk.highest[15:8];
      awm_pkg::ADDR_TEMP_HIGHEST_LOW:   nxt_rd_data = snap_ff[15:8];
      awm_pkg::ADDR_CONTROL_ONE: begin
        nxt_rd_data = {altimeter_select_ff, raw_mode_ff, oversample_field_ff, 1'b0,
                       one_shot_trigger_ff, active_select_ff};
      end
      default:                          nxt_rd_data = awm_pkg::UNMAPPED_READ;
    endcase
  end

  // registered read answer, one cycle after the strobe
  // the byte holds until the next read or a software reset, so a
  // slow host may fetch it late
  always_ff @(posedge clk) begin
    if (!bank_rstn) begin
      rd_data_ff  <= awm_pkg::REG_RESET;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= reg_rd_en;
      if (reg_rd_en)
        rd_data_ff <= nxt_rd_data;
    end
  end

  // outputs, each straight from a flip-flop
  // so nothing downstream sees decode glitches
  assign reg_rd_data      = rd_data_ff;
  assign reg_rd_valid     = rd_valid_ff;
  assign altimeter_select = altimeter_select_ff;
  assign raw_mode         = raw_mode_ff;
  assign oversample_field = oversample_field_ff;
  assign active_select    = active_select_ff;
  assign meas_start       = meas_start_ff;
  assign soft_reset       = soft_reset_ff;
  assign press_window     = press_window_ff;
  assign temp_window      = temp_window_ff;

endmodule
`default_nettype wire

//--- awm_regs_sva.sv
// port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module awm_regs_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        reg_rd_valid,
  // control and windows
  input wire logic        altimeter_select,
  input wire logic        raw_mode,
  input wire logic [2:0]  oversample_field,
  input wire logic        active_select,
  input wire logic        meas_start,
  input wire logic        soft_reset,
  input wire logic [15:0] press_window,
  input wire logic [7:0]  temp_window
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // host strobes that start a multi-step behaviour
  sequence s_ctrl_wr;
    reg_wr_en && reg_addr == awm_pkg::ADDR_CONTROL_ONE;
  endsequence
  sequence s_ctrl_rd;
    reg_rd_en && reg_addr == awm_pkg::ADDR_CONTROL_ONE && !soft_reset;
  endsequence
  // read answer timing
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
  a_rd_quiet: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("spurious read valid");
  // soft reset is excluded since it clears the held byte
  a_rd_hold: assert property (!reg_rd_en && !soft_reset |=> $stable(reg_rd_data))
    else $error("read byte moved");
  // control register layout
  a_ctrl_fields: assert property (s_ctrl_wr |=> {altimeter_select, raw_mode, oversample_field, active_select}
    == {$past(reg_wr_data[7:3]), $past(reg_wr_data[0])}) else $error("control fields wrong");
  a_ctrl_read: assert property (s_ctrl_rd |=> reg_rd_data[7:2] == {altimeter_select, raw_mode, oversample_field,
    1'b0} && reg_rd_data[0] == active_select) else $error("control readback wrong");
  a_kick_cause: assert property (meas_start |-> $past(reg_wr_en) && $past(reg_wr_data[1])
    && $past(reg_addr) == awm_pkg::ADDR_CONTROL_ONE) else $error("one-shot without write");
  a_kick_pulse: assert property (meas_start |=> !meas_start) else $error("one-shot too long");
  // alarm windows
  a_pwin_high: assert property (reg_wr_en && reg_addr == awm_pkg::ADDR_PRESS_WINDOW_HIGH
    |=> press_window[15:8] == $past(reg_wr_data)) else $error("window high wrong");
  a_pwin_low: assert property (reg_wr_en && reg_addr == awm_pkg::ADDR_PRESS_WINDOW_LOW
    |=> press_window[7:0] == $past(reg_wr_data)) else $error("window low wrong");
  a_twin_read: assert property (reg_rd_en && reg_addr == awm_pkg::ADDR_TEMP_WINDOW && !soft_reset
    |=> reg_rd_data == $past(temp_window)) else $error("temp window read wrong");
  a_win_hold: assert property (!reg_wr_en && !soft_reset |=> $stable(press_window) && $stable(temp_window))
    else $error("window moved");
endmodule
bind awm_regs awm_regs_sva u_sva (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .altimeter_select(altimeter_select), .raw_mode(raw_mode), .oversample_field(oversample_field),
  .active_select(active_select), .meas_start(meas_start), .soft_reset(soft_reset),
  .press_window(press_window), .temp_window(temp_window));
`default_nettype wire

//--- awm_track_if.sv
// signals between the register bank and one min/max tracker
`timescale 1ns/1ps
`default_nettype none
interface awm_track_if #(parameter int W = 24);
  logic         clear;
  logic         sample_valid;
  logic [W-1:0] sample;
  logic         signed_mode;
  logic         wr_lowest;
  logic         wr_highest;
  logic [1:0]   wr_byte;
  logic [7:0]   wr_data;
  logic [W-1:0] lowest;
  logic [W-1:0] highest;

  modport owner (output clear, sample_valid, sample, signed_mode, wr_lowest, wr_highest,
                 wr_byte, wr_data, input lowest, highest);
  modport tracker (input clear, sample_valid, sample, signed_mode, wr_lowest, wr_highest,
                   wr_byte, wr_data, output lowest, highest);
endinterface
`default_nettype wire

//--- awm_tracker.sv
// minimum and maximum capture for one quantity, byte writable
`timescale 1ns/1ps
`default_nettype none
module awm_tracker #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic    clk,
  input wire logic    rstn,
  // owner side
  awm_track_if.tracker trk
);

  logic [W-1:0] lowest_ff;
  logic [W-1:0] highest_ff;
  logic         below;
  logic         above;
  logic [W-1:0] nxt_lowest;
  logic [W-1:0] nxt_highest;

  // signed compare in altimeter mode and for temperature, unsigned otherwise
  always_comb begin
    if (trk.signed_mode) begin
      below = $signed(trk.sample) < $signed(lowest_ff);
      above = $signed(trk.sample) > $signed(highest_ff);
    end else begin
      below = trk.sample < lowest_ff;
      above = trk.sample > highest_ff;
    end
  end

  // byte write path; the low byte keeps only its fraction nibble
  always_comb begin
    nxt_lowest  = lowest_ff;
    nxt_highest = highest_ff;
    for (int b = 0; b < W / 8; b++) begin
      if (trk.wr_byte == 2'(b)) begin
        if (trk.wr_lowest)
          nxt_lowest[W-1-8*b -: 8]  = (b == W / 8 - 1) ? (trk.wr_data & awm_pkg::LOW_BYTE_MASK) : trk.wr_data;
        if (trk.wr_highest)
          nxt_highest[W-1-8*b -: 8] = (b == W / 8 - 1) ? (trk.wr_data & awm_pkg::LOW_BYTE_MASK) : trk.wr_data;
      end
    end
  end

  // a zero register counts as empty and takes the next sample;
  // the sample beats a host write in the same cycle so no extreme is lost
  always_ff @(posedge clk) begin
    if (!rstn || trk.clear) begin
      lowest_ff  <= '0;
      highest_ff <= '0;
    end else if (trk.sample_valid) begin
      if (lowest_ff == '0 || below)
        lowest_ff <= trk.sample;
      if (highest_ff == '0 || above)
        highest_ff <= trk.sample;
    end else begin
      lowest_ff  <= nxt_lowest;
      highest_ff <= nxt_highest;
    end
  end

  assign trk.lowest  = lowest_ff;
  assign trk.highest = highest_ff;

endmodule
`default_nettype wire

//--- tb_top.sv
// testbench for the alarm window and min/max register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wr_data;
  logic        reg_rd_en;
  logic [7:0]  reg_rd_data;
  logic        reg_rd_valid;
  logic        meas_valid;
  logic [19:0] meas_press;
  logic [11:0] meas_temp;
  logic        altimeter_select;
  logic        raw_mode;
  logic [2:0]  oversample_field;
  logic        active_select;
  logic        meas_start;
  logic        soft_reset;
  logic [15:0] press_window;
  logic [7:0]  temp_window;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  awm_regs uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .meas_valid(meas_valid),
    .meas_press(meas_press), .meas_temp(meas_temp), .altimeter_select(altimeter_select), .raw_mode(raw_mode),
    .oversample_field(oversample_field), .active_select(active_select), .meas_start(meas_start),
    .soft_reset(soft_reset), .press_window(press_window), .temp_window(temp_window));
  awm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .active_select(active_select));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare helpers, one per kind of result
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk_out({15'h0000, v}, 16'h0001);
    chk_rd(d, e);
  endtask
  // group read, high byte first so the snapshot is taken
  task automatic grp_chk(input logic [7:0] a, input logic [23:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      rd_chk(a + 8'(i), e[23-8*i -: 8]);
    end
  endtask
  // three back-to-back measurements
  task automatic meas3(input logic [59:0] p, input logic [35:0] t);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      meas_valid <= 1'b1;
      meas_press <= p[59-20*i -: 20];
      meas_temp <= t[35-12*i -: 12];
    end
    @(posedge clk);
    meas_valid <= 1'b0;
    meas_press <= ~meas_press;
  endtask
  task automatic clear_ext();
    for (logic [7:0] a = 8'h1c; a <= 8'h25; a++) begin
      host.wr(a, 8'h00);
    end
  endtask
  // every register reads zero after reset, unmapped too
  task automatic t_reset();
    for (logic [7:0] a = 8'h19; a <= 8'h26; a++) begin
      rd_chk(a, 8'h00);
    end
    rd_chk(8'h30, 8'h00);
  endtask
  task automatic t_windows();
    host.wr(awm_pkg::ADDR_PRESS_WINDOW_HIGH, 8'ha5);
    host.wr(awm_pkg::ADDR_PRESS_WINDOW_LOW, 8'h3c);
    host.wr(awm_pkg::ADDR_TEMP_WINDOW, 8'h7e);
    #1;
    chk_out(press_window, 16'ha53c);
    chk_out({8'h00, temp_window}, 16'h007e);
    grp_chk(awm_pkg::ADDR_PRESS_WINDOW_HIGH, 24'ha53c7e, 3);
  endtask
  // control layout, raw mode refusal and one-shot
  task automatic t_ctrl();
    host.ctrl(8'hb9);
    #1;
    chk_out({10'h000, altimeter_select, raw_mode, oversample_field, active_select}, 16'h002f);
    rd_chk(awm_pkg::ADDR_CONTROL_ONE, 8'hb9);
    host.ctrl(8'h50);
    #1;
    chk_out({10'h000, altimeter_select, raw_mode, oversample_field, active_select}, 16'h0014);
    meas3({20'h12345, 20'h00100, 20'habcde}, {12'h190, 12'hf00, 12'h200});
    grp_chk(awm_pkg::ADDR_PRESS_LOWEST_HIGH, 24'h000000, 3);
    host.ctrl(8'h02);
    #1;
    chk_out({15'h0000, meas_start}, 16'h0001);
    @(posedge clk);
    #1;
    chk_out({15'h0000, meas_start}, 16'h0000);
    meas3({20'h00010, 20'h00010, 20'h00010}, {12'h010, 12'h010, 12'h010});
    rd_chk(awm_pkg::ADDR_CONTROL_ONE, 8'h00);
  endtask
  // barometer: unsigned pressure, signed temperature
  task automatic t_baro();
    clear_ext();
    grp_chk(awm_pkg::ADDR_PRESS_HIGHEST_HIGH, 24'h000000, 3);
    meas3({20'h12345, 20'h00100, 20'habcde}, {12'h190, 12'hf00, 12'h200});
    grp_chk(awm_pkg::ADDR_PRESS_LOWEST_HIGH, {20'h00100, 4'h0}, 3);
    grp_chk(awm_pkg::ADDR_PRESS_HIGHEST_HIGH, {20'habcde, 4'h0}, 3);
    grp_chk(awm_pkg::ADDR_TEMP_LOWEST_HIGH, {12'hf00, 12'h000}, 2);
    grp_chk(awm_pkg::ADDR_TEMP_HIGHEST_HIGH, {12'h200, 12'h000}, 2);
  endtask
  // altimeter: signed extremes, masked low nibble
  task automatic t_alt();
    host.ctrl(8'h80);
    clear_ext();
    meas3({20'h00500, 20'hffe00, 20'h00300}, {12'h050, 12'h040, 12'h060});
    grp_chk(awm_pkg::ADDR_PRESS_LOWEST_HIGH, {20'hffe00, 4'h0}, 3);
    grp_chk(awm_pkg::ADDR_PRESS_HIGHEST_HIGH, {20'h00500, 4'h0}, 3);
    grp_chk(awm_pkg::ADDR_TEMP_LOWEST_HIGH, {12'h040, 12'h000}, 2);
    host.wr(awm_pkg::ADDR_TEMP_HIGHEST_LOW, 8'hff);
    grp_chk(awm_pkg::ADDR_TEMP_HIGHEST_HIGH, 24'h06f000, 2);
  endtask
  // software reset empties the bank mid-run
  task automatic t_soft();
    host.ctrl(8'h84);
    #1;
    chk_out({15'h0000, soft_reset}, 16'h0001);
    @(posedge clk);
    #1;
    chk_out({15'h0000, soft_reset}, 16'h0000);
    chk_out(press_window, 16'h0000);
    grp_chk(awm_pkg::ADDR_TEMP_HIGHEST_HIGH, 24'h000000, 2);
    rd_chk(awm_pkg::ADDR_CONTROL_ONE, 8'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly two hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim();
    end
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    meas_valid = 1'b0;
    meas_press = 20'h00000;
    meas_temp = 12'h000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_windows();
    t_ctrl();
    t_baro();
    t_alt();
    t_soft();
    end_sim();
  end
endmodule
`default_nettype wire
